// >>> pkg/rrie_pkg.sv
// Package: constants for the return/reset instruction execution block
package rrie_pkg;
    localparam int PC_W = 21;
    localparam int STK_DEPTH = 31;
    localparam int SP_W = 5;
    localparam logic [15:0] OPC_SWRESET = 16'h00ff;
    localparam logic [14:0] OPC_RETURN_FROM_INTERRUPT_OP_TOP = 15'h0008;
    localparam logic [7:0] OPC_RETURN_WITH_LITERAL_OP_TOP = 8'h0c;
    localparam logic [7:0] W_RST = 8'h00;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [3:0] BSR_RST = 4'h0;
    localparam logic [PC_W-1:0] PC_RST = 21'h00000;
    localparam logic [SP_W-1:0] SP_RST = 5'h00;
    localparam logic [1:0] Q1 = 2'h0;
    localparam logic [1:0] Q2 = 2'h1;
    localparam logic [1:0] Q4 = 2'h3;
    // APB register map (byte addresses)
    localparam logic [7:0] A_INSTR = 8'h00;
    localparam logic [7:0] A_CTRL = 8'h04;
    localparam logic [7:0] A_W = 8'h08;
    localparam logic [7:0] A_STATUS = 8'h0c;
    localparam logic [7:0] A_PC = 8'h10;
    localparam logic [7:0] A_SP = 8'h14;
    localparam logic [7:0] A_SHADOW = 8'h18;
    localparam logic [7:0] A_TOS = 8'h1c;
    localparam logic [7:0] A_LATCH = 8'h20;
    typedef enum logic [1:0] {RRIE_IDLE, RRIE_EXEC, RRIE_NOP} rrie_state_type;
endpackage : rrie_pkg

// >>> design/rrie_qclk.sv
// Quarter-cycle phase generator for the four-phase instruction cycle
`timescale 1ns/1ps
`default_nettype none
module rrie_qclk
    import rrie_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sync_clr,
    output logic [1:0] q_ff
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_ff <= Q1;
        end else if (sync_clr) begin
            q_ff <= Q1;
        end else begin
            q_ff <= q_ff + 2'h1;
        end
    end
endmodule // rrie_qclk
`default_nettype wire

// >>> design/rrie_core.sv
// Execution of software reset, return-from-interrupt and literal-return
// Operation
// - Software reset returns every register and flag except the stack array to master-clear values.
// - Software reset is one word, one cycle; reset starts in phase two.
// - Interrupt return pops stack into PC; two cycles, second a no-op.
// - Interrupt return sets high or low global enable in phase four.
// - With s set, W, status and bank select reload from shadows.
// - Literal return loads W with opcode low-byte literal.
// - Literal return pops stack into PC; two cycles, second a no-op.
// - Neither return touches the upper and high PC latches.
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rrie_core
    import rrie_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic busy_ff,
    output logic global_int_enable_high,
    output logic peripheral_int_enable_low
);
    // ****************************************
    // State
    // ****************************************
    logic [1:0] q_ff;
    rrie_state_type state_ff;
    logic [15:0] opc_ff;
    logic pend_ff;
    logic swrst;
    logic [7:0] w_ff, status_ff, w_sh_ff, status_sh_ff;
    logic [3:0] bsr_ff, bsr_sh_ff;
    logic [PC_W-1:0] pc_ff;
    logic [SP_W-1:0] sp_ff;
    logic [PC_W-1:0] stk_ff [STK_DEPTH+1];
    logic [7:0] latch_h_ff, latch_u_ff;
    logic gieh_ff, giel_ff, prio_ff;
    logic wr, wr_ok, rd_ok, is_return_from_interrupt_op, is_return_with_literal_op, is_rst, q_start;
    logic [PC_W-1:0] top_of_stack;

    assign wr = psel && penable && pwrite;
    // Refused while an opcode waits or runs, so it always sees settled state
    assign wr_ok = wr && !pend_ff && state_ff == RRIE_IDLE;
    assign top_of_stack = stk_ff[sp_ff];
    assign is_rst = opc_ff == OPC_SWRESET;
    assign is_return_from_interrupt_op = opc_ff[15:1] == OPC_RETURN_FROM_INTERRUPT_OP_TOP;
    assign is_return_with_literal_op = opc_ff[15:8] == OPC_RETURN_WITH_LITERAL_OP_TOP;
    // Reset starts at phase two of the decoding cycle
    assign swrst = state_ff == RRIE_EXEC && is_rst && q_ff == Q2;
    assign q_start = pend_ff && q_ff == Q4 && state_ff == RRIE_IDLE;

    rrie_qclk u_q (
        .clk(clk),
        .rst_n(rst_n),
        .sync_clr(swrst),
        .q_ff(q_ff)
    );

    // ****************************************
    // Sequencer
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= RRIE_IDLE;
            pend_ff <= 1'b0;
            opc_ff <= 16'h0000;
        end else if (swrst) begin
            state_ff <= RRIE_IDLE;
            pend_ff <= 1'b0;
            opc_ff <= 16'h0000;
        end else begin
            if (wr_ok && paddr == A_INSTR) begin
                opc_ff <= pwdata[15:0];
                pend_ff <= 1'b1;
            end
            case (state_ff)
                RRIE_IDLE: begin
                    if (q_start) begin
                        state_ff <= RRIE_EXEC;
                        pend_ff <= 1'b0;
                    end
                end
                RRIE_EXEC: begin
                    if (q_ff == Q4) begin
                        state_ff <= (is_return_from_interrupt_op || is_return_with_literal_op) ? RRIE_NOP : RRIE_IDLE;
                    end
                end
                RRIE_NOP: begin
                    if (q_ff == Q4) begin
                        state_ff <= RRIE_IDLE;
                    end
                end
                default: state_ff <= RRIE_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_ff <= 1'b0;
        end else begin
            busy_ff <= pend_ff || state_ff != RRIE_IDLE;
        end
    end

    // ****************************************
    // Core registers
    // ****************************************
    logic pop;
    assign pop = state_ff == RRIE_EXEC && q_ff == Q4 && (is_return_from_interrupt_op || is_return_with_literal_op);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            w_ff <= W_RST;
            status_ff <= STATUS_RST;
            bsr_ff <= BSR_RST;
            pc_ff <= PC_RST;
            sp_ff <= SP_RST;
            gieh_ff <= 1'b0;
            giel_ff <= 1'b0;
        end else if (swrst) begin
            w_ff <= W_RST;
            status_ff <= STATUS_RST;
            bsr_ff <= BSR_RST;
            pc_ff <= PC_RST;
            sp_ff <= SP_RST;
            gieh_ff <= 1'b0;
            giel_ff <= 1'b0;
        end else if (pop) begin
            pc_ff <= top_of_stack;
            sp_ff <= sp_ff - 5'h01;
            if (is_return_with_literal_op) begin
                w_ff <= opc_ff[7:0];
            end else begin
                if (prio_ff) begin
                    gieh_ff <= 1'b1;
                end else begin
                    giel_ff <= 1'b1;
                end
                if (opc_ff[0]) begin
                    w_ff <= w_sh_ff;
                    status_ff <= status_sh_ff;
                    bsr_ff <= bsr_sh_ff;
                end
            end
        end else if (wr_ok) begin
            case (paddr)
                A_W: w_ff <= pwdata[7:0];
                A_STATUS: status_ff <= pwdata[7:0];
                A_PC: pc_ff <= pwdata[PC_W-1:0];
                A_SP: sp_ff <= pwdata[SP_W-1:0];
                A_CTRL: begin
                    gieh_ff <= pwdata[1];
                    giel_ff <= pwdata[2];
                    bsr_ff <= pwdata[11:8];
                end
                default: ;
            endcase
        end
    end

    // Shadows, stack entries, latches and priority select are software-loaded only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            w_sh_ff <= W_RST;
            status_sh_ff <= STATUS_RST;
            bsr_sh_ff <= BSR_RST;
            latch_h_ff <= 8'h00;
            latch_u_ff <= 8'h00;
            prio_ff <= 1'b0;
        end else if (swrst) begin
            w_sh_ff <= W_RST;
            status_sh_ff <= STATUS_RST;
            bsr_sh_ff <= BSR_RST;
            latch_h_ff <= 8'h00;
            latch_u_ff <= 8'h00;
            prio_ff <= 1'b0;
        end else if (wr_ok) begin
            // Latches never change on a return: only this bus path and the two resets write them
            case (paddr)
                A_SHADOW: begin
                    w_sh_ff <= pwdata[7:0];
                    status_sh_ff <= pwdata[15:8];
                    bsr_sh_ff <= pwdata[19:16];
                end
                A_LATCH: begin
                    latch_h_ff <= pwdata[7:0];
                    latch_u_ff <= pwdata[15:8];
                end
                A_CTRL: prio_ff <= pwdata[0];
                default: ;
            endcase
        end
    end

    // Stack array holds no reset; pointer reset makes contents irrelevant
    always_ff @(posedge clk) begin
        if (wr_ok && paddr == A_TOS) begin
            stk_ff[sp_ff] <= pwdata[PC_W-1:0];
        end
    end

    // ****************************************
    // APB slave
    // ****************************************
    always_comb begin
        rd_ok = 1'b1;
        case (paddr)
            A_INSTR, A_CTRL, A_W, A_STATUS, A_PC, A_SP, A_SHADOW, A_TOS, A_LATCH: rd_ok = 1'b1;
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            global_int_enable_high <= 1'b0;
            peripheral_int_enable_low <= 1'b0;
        end else begin
            global_int_enable_high <= gieh_ff;
            peripheral_int_enable_low <= giel_ff;
            pready <= psel && !penable;
            pslverr <= psel && !penable && !rd_ok;
            prdata <= 32'h00000000;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    A_INSTR: prdata <= {15'h0000, pend_ff, opc_ff};
                    A_CTRL: prdata <= {20'h00000, bsr_ff, 5'h00, giel_ff, gieh_ff, prio_ff};
                    A_W: prdata <= {24'h000000, w_ff};
                    A_STATUS: prdata <= {24'h000000, status_ff};
                    A_PC: prdata <= {11'h000, pc_ff};
                    A_SP: prdata <= {27'h0000000, sp_ff};
                    A_SHADOW: prdata <= {12'h000, bsr_sh_ff, status_sh_ff, w_sh_ff};
                    A_TOS: prdata <= {11'h000, top_of_stack};
                    A_LATCH: prdata <= {16'h0000, latch_u_ff, latch_h_ff};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // rrie_core
`default_nettype wire

// >>> tb/rrie_checker.sv
// Checker: port-level assertions for rrie_core
`timescale 1ns/1ps
`default_nettype none
module rrie_checker
    import rrie_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic busy_ff,
    input wire logic global_int_enable_high,
    input wire logic peripheral_int_enable_low
);
    // ****************
    // Opcode tracking
    // ****************
    logic [15:0] last_op_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_op_ff <= 16'h0000;
        end else if (psel && penable && pwrite && paddr == A_INSTR && !busy_ff) begin
            last_op_ff <= pwdata[15:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no pready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_err_unmapped: assert property (psel && !penable && paddr > A_LATCH |=> pslverr)
        else $error("no error on unmapped address");
    a_err_mapped: assert property (psel && !penable && paddr <= A_LATCH && paddr[1:0] == 2'h0 |=> !pslverr)
        else $error("error on mapped address");
    a_busy_on_return: assert property (psel && penable && pwrite && paddr == A_INSTR && !busy_ff
        && pwdata[15:8] == OPC_RETURN_WITH_LITERAL_OP_TOP |-> ##2 busy_ff)
        else $error("literal return not started");
    a_return_two_cycles: assert property ($rose(busy_ff) && last_op_ff[15:8] == OPC_RETURN_WITH_LITERAL_OP_TOP
        |-> busy_ff [*8] ##[1:8] !busy_ff)
        else $error("literal return length wrong");
    a_int_return_enable: assert property ($fell(busy_ff) && last_op_ff[15:1] == OPC_RETURN_FROM_INTERRUPT_OP_TOP
        |-> global_int_enable_high || peripheral_int_enable_low)
        else $error("no enable after interrupt return");
    a_swreset_clears: assert property ($fell(busy_ff) && last_op_ff == OPC_SWRESET
        |-> !global_int_enable_high && !peripheral_int_enable_low)
        else $error("enables survive software reset");
    a_swreset_short: assert property ($rose(busy_ff) && last_op_ff == OPC_SWRESET |-> ##[1:8] !busy_ff)
        else $error("software reset too long");
endmodule // rrie_checker
bind rrie_core rrie_checker rrie_checker_inst (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .busy_ff, .global_int_enable_high, .peripheral_int_enable_low);
`default_nettype wire

// >>> tb/testbench.sv
// Testbench: APB-driven checks of return and reset execution
`timescale 1ns/1ps
`default_nettype none
module testbench
    import rrie_pkg::*;
;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, busy_ff, err_s;
    logic global_int_enable_high, peripheral_int_enable_low;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int bad_count, n_compared;
    rrie_core rrie_core_inst (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .busy_ff, .global_int_enable_high, .peripheral_int_enable_low);
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ****************
    // Tasks
    // ****************
    task report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Request held until the rising edge that sees pready high; data taken there
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (n >= 40) begin
            bad_count++;
            report_and_stop;
        end
        q = prdata;
        err_s = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task wait_idle;
        int n;
        n = 0;
        // Busy rises one edge after the opcode write lands
        repeat (2) @(posedge clk);
        while (busy_ff !== 1'b0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        if (n >= 100) begin
            bad_count++;
            report_and_stop;
        end
    endtask
    // ****************
    // Main sequence
    // ****************
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        bad_count = 0;
        n_compared = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rd(A_W, 32'h0);
        rd(A_CTRL, 32'h0);
        rd(8'h40, 32'h0);
        chk({31'h0, err_s}, 32'h1);
        $display("reset and map test done");
        xfer(1'b1, A_SP, 32'h2);
        xfer(1'b1, A_TOS, 32'h012345);
        xfer(1'b1, A_LATCH, 32'habcd);
        xfer(1'b1, A_INSTR, 32'h0c5a);
        wait_idle;
        rd(A_W, 32'h5a);
        rd(A_PC, 32'h012345);
        rd(A_SP, 32'h1);
        $display("literal return test done");
        xfer(1'b1, A_SHADOW, 32'h00090577);
        xfer(1'b1, A_CTRL, 32'h1);
        xfer(1'b1, A_TOS, 32'h0abcd);
        xfer(1'b1, A_INSTR, 32'h0011);
        wait_idle;
        rd(A_PC, 32'h0abcd);
        rd(A_W, 32'h77);
        rd(A_STATUS, 32'h05);
        rd(A_CTRL, 32'h903);
        chk({31'h0, global_int_enable_high}, 32'h1);
        rd(A_SP, 32'h0);
        rd(A_LATCH, 32'habcd);
        $display("interrupt return with shadows test done");
        xfer(1'b1, A_SP, 32'h3);
        xfer(1'b1, A_TOS, 32'h777);
        xfer(1'b1, A_CTRL, 32'h0);
        xfer(1'b1, A_W, 32'h33);
        xfer(1'b1, A_STATUS, 32'h22);
        xfer(1'b1, A_INSTR, 32'h0010);
        // Issued mid-execution; must be dropped
        xfer(1'b1, A_W, 32'hee);
        wait_idle;
        rd(A_W, 32'h33);
        rd(A_STATUS, 32'h22);
        rd(A_CTRL, 32'h4);
        chk({31'h0, peripheral_int_enable_low}, 32'h1);
        chk({31'h0, global_int_enable_high}, 32'h0);
        rd(A_PC, 32'h777);
        rd(A_SP, 32'h2);
        $display("interrupt return without shadows test done");
        xfer(1'b1, A_INSTR, 32'h00ff);
        wait_idle;
        rd(A_W, 32'h0);
        rd(A_STATUS, 32'h0);
        rd(A_PC, 32'h0);
        rd(A_SP, 32'h0);
        rd(A_CTRL, 32'h0);
        rd(A_LATCH, 32'h0);
        rd(A_SHADOW, 32'h0);
        rd(A_INSTR, 32'h0);
        chk({30'h0, global_int_enable_high, peripheral_int_enable_low}, 32'h0);
        $display("software reset test done");
        report_and_stop;
    end
endmodule // testbench
`default_nettype wire
